// ---- rtl/ttfc_top.v ----
// Function sequencing and byte transfer control for a tape controller
`timescale 1ns/1ns
`default_nettype none
`include "ttfc_map.vh"
module ttfc_top #(
    parameter GAP_CLKS = `TTFC_GAP_CLKS,
    parameter AW       = 18
) (
    input  wire          CLK,
    input  wire          RST_N,
    input  wire          GO,
    input  wire [2:0]    FUNC,
    input  wire          UNIT_SEL,
    input  wire          PARITY_EVEN,
    input  wire          EXTENDED_GAP_WRITE,
    input  wire [15:0]   READ_CHECK_SELECT_REGISTER,
    input  wire          CNT_LOAD,
    input  wire [15:0]   CNT_LOAD_VAL,
    input  wire          ADDR_LOAD,
    input  wire [AW-1:0] ADDR_LOAD_VAL,
    input  wire [7:0]    WR_BYTE,
    input  wire          WR_BYTE_VALID,
    output wire          WR_BYTE_READY,
    input  wire [8:0]    TAPE_RD_CHAR,
    input  wire          TAPE_RD_STROBE,
    input  wire          TAPE_CRC_STROBE,
    input  wire          TAPE_LRC_STROBE,
    input  wire          TAPE_RECORD_END,
    input  wire          WRITE_STROBE_PULSE,
    input  wire [1:0]    UNIT_READY_IN,
    input  wire [1:0]    TAPE_START_MARKER,
    input  wire [1:0]    UNIT_REMOTE,
    input  wire          VPAR_ERR,
    input  wire          LPAR_ERR,
    input  wire          XFER_ERR,
    output reg  [7:0]    MEM_DATA,
    output reg  [AW-1:0] MEM_ADDR,
    output reg           MEM_HIGH_BYTE,
    output wire          MEM_VALID,
    input  wire          MEM_READY,
    output reg  [7:0]    TAPE_WR_DATA,
    output reg           TAPE_WR_PARITY_ODD,
    output wire          WRITE_DATA_READY_LEVEL,
    output reg           TAPE_REVERSE,
    output reg           TAPE_FORWARD,
    output reg           TAPE_REWIND,
    output reg           TAPE_LOCAL,
    output reg           TAPE_ERASE,
    output reg  [7:0]    DATA_BUFFER,
    output reg  [15:0]   RECORD_BYTE_COUNTER,
    output reg  [AW-1:0] MEMORY_ADDRESS_POINTER,
    output wire          CONTROLLER_READY_FLAG,
    output wire          UNIT_READY_FLAG,
    output wire [15:0]   STATUS
);
    localparam S_IDLE = 3'h0;
    localparam S_GAP  = 3'h1;
    localparam S_WR   = 3'h2;
    localparam S_RD   = 3'h3;
    localparam S_SP   = 3'h4;
    localparam S_RW   = 3'h5;
    localparam S_EOF  = 3'h6;
    localparam S_WAIT = 3'h7;
    localparam [15:0] GAP_N = GAP_CLKS[15:0];

    reg  [2:0]  state_r;
    reg  [2:0]  fn_r;
    reg  [15:0] gap_cnt_r;
    reg         err_r;
    reg         illegal_r;
    reg         half_r;
    reg         busy_r;
    reg         loaded_r;
    wire        wr_in_rdy;
    wire        unit_rdy;
    wire        rd_push;
    wire        rd_in_rdy;
    wire [7:0]  rd_out;
    wire        wr_valid;
    wire [7:0]  wr_out;
    wire        wr_take;
    wire        mem_take;
    wire [15:0] cnt_inc;

    // Status sees only the transport picked by the command
    function sel_bit;
        input [1:0] v;
        input       s;
        begin
            sel_bit = s ? v[1] : v[0];
        end
    endfunction

    assign unit_rdy = sel_bit(UNIT_READY_IN, UNIT_SEL);
    assign cnt_inc  = RECORD_BYTE_COUNTER + 16'h0001;
    assign rd_push  = (state_r == S_RD) & TAPE_RD_STROBE;

    // Read path: characters buffered toward memory, parity dropped
    ttfc_buf #(.W(8)) u_rd_buf (
        .clk       (CLK),
        .rst_n     (RST_N),
        .in_data   (TAPE_RD_CHAR[7:0]),
        .in_valid  (rd_push),
        .in_ready  (rd_in_rdy),
        .out_data  (rd_out),
        .out_valid (MEM_VALID),
        .out_ready (MEM_READY)
    );
    assign mem_take = MEM_VALID & MEM_READY;

    // Write path: a bus stall never drops a byte
    ttfc_buf #(.W(8)) u_wr_buf (
        .clk       (CLK),
        .rst_n     (RST_N),
        .in_data   (WR_BYTE),
        .in_valid  (WR_BYTE_VALID & (state_r == S_WR)),
        .in_ready  (wr_in_rdy),
        .out_data  (wr_out),
        .out_valid (wr_valid),
        .out_ready (wr_take)
    );
    // Bytes offered outside a write would be lost, so refuse them
    assign WR_BYTE_READY = wr_in_rdy & (state_r == S_WR);
    // Ready level only once the character stands on the data lines
    assign WRITE_DATA_READY_LEVEL = ((state_r == S_WR) & wr_valid & loaded_r)
                                  | (state_r == S_EOF);
    assign wr_take = (state_r == S_WR) & WRITE_STROBE_PULSE & wr_valid
                   & loaded_r;

    assign CONTROLLER_READY_FLAG = ~busy_r;
    assign UNIT_READY_FLAG = unit_rdy & ~busy_r;
    assign STATUS = {err_r, illegal_r, VPAR_ERR | LPAR_ERR, XFER_ERR,
                     sel_bit(TAPE_START_MARKER, UNIT_SEL),
                     sel_bit(UNIT_REMOTE, UNIT_SEL),
                     9'h000, UNIT_READY_FLAG};

    // Memory side: data and address come from registers
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            MEM_DATA      <= 8'h00;
            MEM_ADDR      <= {AW{1'b0}};
            MEM_HIGH_BYTE <= 1'b0;
            half_r        <= 1'b0;
        end else if (state_r == S_IDLE && GO) begin
            half_r <= 1'b0;
        end else if (mem_take) begin
            MEM_DATA      <= rd_out;
            MEM_ADDR      <= MEMORY_ADDRESS_POINTER;
            MEM_HIGH_BYTE <= half_r;
            half_r        <= ~half_r;
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r                <= S_IDLE;
            fn_r                   <= 3'h0;
            gap_cnt_r              <= 16'h0000;
            busy_r                 <= 1'b0;
            loaded_r               <= 1'b0;
            err_r                  <= 1'b0;
            illegal_r              <= 1'b0;
            DATA_BUFFER            <= 8'h00;
            RECORD_BYTE_COUNTER    <= 16'h0000;
            MEMORY_ADDRESS_POINTER <= {AW{1'b0}};
            TAPE_WR_DATA           <= 8'h00;
            TAPE_WR_PARITY_ODD     <= 1'b1;
            TAPE_REVERSE           <= 1'b0;
            TAPE_FORWARD           <= 1'b0;
            TAPE_REWIND            <= 1'b0;
            TAPE_LOCAL             <= 1'b0;
            TAPE_ERASE             <= 1'b0;
        end else begin
            if (CNT_LOAD && state_r == S_IDLE) begin
                RECORD_BYTE_COUNTER <= CNT_LOAD_VAL;
            end
            if (ADDR_LOAD && state_r == S_IDLE) begin
                MEMORY_ADDRESS_POINTER <= ADDR_LOAD_VAL;
            end
            case (state_r)
            S_IDLE: begin
                if (GO) begin
                    fn_r      <= FUNC;
                    busy_r    <= 1'b1;
                    loaded_r  <= 1'b0;
                    err_r     <= 1'b0;
                    illegal_r <= ~unit_rdy;
                    TAPE_WR_PARITY_ODD <= ~PARITY_EVEN;
                    gap_cnt_r <= GAP_N;
                    if (!unit_rdy) begin
                        state_r <= S_WAIT;
                    end else begin
                        case (FUNC)
                        `TTFC_FN_OFFLINE: begin
                            TAPE_LOCAL  <= 1'b1;
                            TAPE_REWIND <= 1'b1;
                            state_r     <= S_RW;
                        end
                        `TTFC_FN_READ: begin
                            TAPE_FORWARD <= 1'b1;
                            state_r      <= S_RD;
                        end
                        `TTFC_FN_WRITE: begin
                            TAPE_FORWARD <= 1'b1;
                            state_r      <= S_WR;
                        end
                        `TTFC_FN_WEOF: begin
                            TAPE_FORWARD <= 1'b1;
                            TAPE_WR_DATA <= `TTFC_EOF_CHAR;
                            // Gap only without the extended-gap command
                            TAPE_ERASE <= ~EXTENDED_GAP_WRITE;
                            state_r <= EXTENDED_GAP_WRITE ? S_EOF : S_GAP;
                        end
                        `TTFC_FN_SPFWD: begin
                            TAPE_FORWARD <= 1'b1;
                            state_r      <= S_SP;
                        end
                        `TTFC_FN_SPREV: begin
                            TAPE_REVERSE <= 1'b1;
                            state_r      <= S_SP;
                        end
                        `TTFC_FN_WXGAP: begin
                            TAPE_FORWARD <= 1'b1;
                            TAPE_ERASE   <= 1'b1;
                            state_r      <= S_GAP;
                        end
                        `TTFC_FN_REWIND: begin
                            TAPE_REWIND <= 1'b1;
                            state_r     <= S_RW;
                        end
                        default: state_r <= S_WAIT;
                        endcase
                    end
                end
            end
            S_GAP: begin
                // Erased length timed in clocks before the first frame
                if (gap_cnt_r == 16'h0001) begin
                    TAPE_ERASE <= 1'b0;
                    state_r <= (fn_r == `TTFC_FN_WEOF) ? S_EOF : S_WR;
                end
                gap_cnt_r <= gap_cnt_r - 16'h0001;
            end
            S_WR: begin
                if (wr_take) begin
                    loaded_r <= 1'b0;
                    RECORD_BYTE_COUNTER <= cnt_inc;
                    MEMORY_ADDRESS_POINTER <=
                        MEMORY_ADDRESS_POINTER + 1'b1;
                    if (cnt_inc == 16'h0000) begin
                        state_r <= S_WAIT;
                    end
                end else if (wr_valid) begin
                    TAPE_WR_DATA <= wr_out;
                    loaded_r     <= 1'b1;
                end
            end
            S_EOF: begin
                TAPE_WR_DATA <= `TTFC_EOF_CHAR;
                if (WRITE_STROBE_PULSE) begin
                    state_r <= S_WAIT;
                end
            end
            S_RD: begin
                if (rd_push && !rd_in_rdy) begin
                    err_r   <= 1'b1;
                    state_r <= S_WAIT;
                end else if (rd_push) begin
                    RECORD_BYTE_COUNTER <= cnt_inc;
                    MEMORY_ADDRESS_POINTER <=
                        MEMORY_ADDRESS_POINTER + 1'b1;
                    DATA_BUFFER <= TAPE_RD_CHAR[7:0];
                end
                if (XFER_ERR) begin
                    // Pointer stays put unless a character is pushed in the same cycle
                    err_r   <= 1'b1;
                    state_r <= S_WAIT;
                end
                if (TAPE_CRC_STROBE
                    && !READ_CHECK_SELECT_REGISTER[`TTFC_SEL_BIT]) begin
                    DATA_BUFFER <= TAPE_RD_CHAR[7:0];
                end
                if (TAPE_LRC_STROBE
                    && READ_CHECK_SELECT_REGISTER[`TTFC_SEL_BIT]) begin
                    DATA_BUFFER <= TAPE_RD_CHAR[7:0];
                end
                if (TAPE_RECORD_END) begin
                    state_r <= S_WAIT;
                end
            end
            S_SP: begin
                // Positioning only: no memory or tape data path used
                if (TAPE_RECORD_END) begin
                    RECORD_BYTE_COUNTER <= cnt_inc;
                    if (cnt_inc == 16'h0000) begin
                        state_r <= S_WAIT;
                    end
                end
            end
            S_RW: begin
                if (sel_bit(TAPE_START_MARKER, UNIT_SEL)) begin
                    TAPE_REWIND <= 1'b0;
                    state_r     <= S_WAIT;
                end
            end
            S_WAIT: begin
                TAPE_FORWARD <= 1'b0;
                TAPE_REVERSE <= 1'b0;
                TAPE_ERASE   <= 1'b0;
                if (!MEM_VALID) begin
                    busy_r  <= 1'b0;
                    state_r <= S_IDLE;
                end
            end
            default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- rtl/ttfc_map.vh ----
// Constants for the tape transfer function control block
`ifndef TTFC_MAP_VH
`define TTFC_MAP_VH
`define TTFC_FN_OFFLINE   3'h0
`define TTFC_FN_READ      3'h1
`define TTFC_FN_WRITE     3'h2
`define TTFC_FN_WEOF      3'h3
`define TTFC_FN_SPFWD     3'h4
`define TTFC_FN_SPREV     3'h5
`define TTFC_FN_WXGAP     3'h6
`define TTFC_FN_REWIND    3'h7
`define TTFC_EOF_CHAR     8'h13
`define TTFC_GAP_INCH     3
`define TTFC_GAP_CLKS     3000
`define TTFC_SEL_BIT      14
`define TTFC_BUF_DEPTH    2
`endif

// ---- rtl/ttfc_buf.v ----
// Two-entry valid/ready buffer with combinational read data
`timescale 1ns/1ns
`default_nettype none
module ttfc_buf #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output wire         in_ready,
    output reg  [W-1:0] out_data,
    output wire         out_valid,
    input  wire         out_ready
);
    reg [W-1:0] mem_r [0:1];
    reg         wp_r;
    reg         rp_r;
    reg [1:0]   cnt_r;
    wire        push;
    wire        pop;
    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    always @* begin
        out_data = mem_r[rp_r];
    end
    always @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// ---- verification/ttfc_sva.sv ----
// Port-level assertions for the tape transfer control block
`timescale 1ns/1ns
`default_nettype none
module ttfc_sva #(
    parameter AW = 18
) (
    input wire logic          CLK,
    input wire logic          RST_N,
    input wire logic          GO,
    input wire logic          UNIT_SEL,
    input wire logic          VPAR_ERR,
    input wire logic          LPAR_ERR,
    input wire logic          CNT_LOAD,
    input wire logic          ADDR_LOAD,
    input wire logic [1:0]    TAPE_START_MARKER,
    input wire logic          WRITE_STROBE_PULSE,
    input wire logic          WRITE_DATA_READY_LEVEL,
    input wire logic          MEM_VALID,
    input wire logic          TAPE_REVERSE,
    input wire logic          TAPE_REWIND,
    input wire logic          TAPE_ERASE,
    input wire logic [15:0]   RECORD_BYTE_COUNTER,
    input wire logic [AW-1:0] MEMORY_ADDRESS_POINTER,
    input wire logic          CONTROLLER_READY_FLAG,
    input wire logic          UNIT_READY_FLAG,
    input wire logic [15:0]   STATUS
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    AST_GO_DROP: assert property (
        GO && CONTROLLER_READY_FLAG |=>
        !CONTROLLER_READY_FLAG && !UNIT_READY_FLAG)
        else $error("ready flags stayed up after start");
    AST_WDR_HOLD: assert property (
        WRITE_DATA_READY_LEVEL && !WRITE_STROBE_PULSE |=>
        WRITE_DATA_READY_LEVEL)
        else $error("write ready dropped before strobe");
    // Loads are the only other way either register may move
    AST_PTR_STEP: assert property (
        MEMORY_ADDRESS_POINTER != $past(MEMORY_ADDRESS_POINTER)
        && !$past(ADDR_LOAD) |->
        MEMORY_ADDRESS_POINTER == $past(MEMORY_ADDRESS_POINTER) + 1'b1)
        else $error("address pointer moved by other than one");
    AST_CNT_STEP: assert property (
        RECORD_BYTE_COUNTER != $past(RECORD_BYTE_COUNTER)
        && !$past(CNT_LOAD) |->
        RECORD_BYTE_COUNTER == $past(RECORD_BYTE_COUNTER) + 16'h1)
        else $error("counter moved by other than one");
    AST_STAT_PAR: assert property (
        STATUS[13] == (VPAR_ERR || LPAR_ERR))
        else $error("parity status not merged");
    AST_STAT_SEL: assert property (
        STATUS[11] == TAPE_START_MARKER[UNIT_SEL]
        && STATUS[0] == UNIT_READY_FLAG)
        else $error("status does not follow selected unit");
    AST_REV_QUIET: assert property (
        TAPE_REVERSE || TAPE_REWIND |->
        !MEM_VALID && !WRITE_DATA_READY_LEVEL)
        else $error("data moved during reverse motion");
    AST_ERASE_FIRST: assert property (
        TAPE_ERASE |-> !WRITE_DATA_READY_LEVEL)
        else $error("character offered during gap erase");
endmodule
bind ttfc_top ttfc_sva #(.AW(AW)) u_sva (.*);
`default_nettype wire

// ---- verification/ttfc_xport.sv ----
// Behavioural master transport: strobes, record ends, start markers
`timescale 1ns/1ns
`default_nettype none
module ttfc_xport (
    input  wire logic  clk,
    input  wire logic  write_data_ready_level,
    input  wire logic  fwd,
    input  wire logic  rev,
    input  wire logic  wind,
    input  wire logic  sel,
    input  wire logic  spc,
    input  wire logic  eor,
    output logic       write_strobe_pulse,
    output logic       rec_end,
    output logic [1:0] marker
);
    int d;
    int w;

    initial begin
        write_strobe_pulse = 1'b0;
        rec_end = 1'b0;
        marker = 2'h0;
        d = 0;
        w = 0;
    end

    always @(negedge clk) begin
        write_strobe_pulse <= 1'b0;
        rec_end <= eor;
        d <= d + 1;
        w <= wind ? w + 1 : 0;
        // Random strobe delay gives both prompt and slow transports
        if (write_data_ready_level && !write_strobe_pulse && d > 2) begin
            write_strobe_pulse <= 1'b1;
            d <= $urandom_range(2);
        end
        if (spc && (fwd || rev) && d > 7) begin
            rec_end <= 1'b1;
            d <= 0;
        end
        if (w > 20)
            marker[sel] <= 1'b1;
        if (fwd)
            marker <= 2'h0;
    end
endmodule
`default_nettype wire

// ---- verification/ttfc_top_tb.sv ----
// Self-checking bench for the tape transfer control block
`timescale 1ns/1ns
`default_nettype none
module ttfc_top_tb;
    logic        CLK, RST_N, GO, UNIT_SEL, PARITY_EVEN, CNT_LOAD;
    logic        EXTENDED_GAP_WRITE, ADDR_LOAD, WR_BYTE_VALID;
    logic        WR_BYTE_READY, TAPE_RD_STROBE, TAPE_CRC_STROBE;
    logic        TAPE_LRC_STROBE, TAPE_RECORD_END, WRITE_STROBE_PULSE;
    logic        VPAR_ERR, LPAR_ERR, XFER_ERR, MEM_HIGH_BYTE, MEM_VALID;
    logic        MEM_READY, TAPE_WR_PARITY_ODD, WRITE_DATA_READY_LEVEL;
    logic        TAPE_REVERSE, TAPE_FORWARD, TAPE_REWIND, TAPE_LOCAL;
    logic        TAPE_ERASE, CONTROLLER_READY_FLAG, UNIT_READY_FLAG;
    logic [2:0]  FUNC;
    logic [1:0]  UNIT_READY_IN, TAPE_START_MARKER, UNIT_REMOTE;
    logic [7:0]  WR_BYTE, MEM_DATA, TAPE_WR_DATA, DATA_BUFFER, b;
    logic [8:0]  TAPE_RD_CHAR, c, c1, c2;
    logic [15:0] READ_CHECK_SELECT_REGISTER, CNT_LOAD_VAL;
    logic [15:0] RECORD_BYTE_COUNTER, STATUS;
    logic [17:0] ADDR_LOAD_VAL, MEM_ADDR, MEMORY_ADDRESS_POINTER, a;
    logic [7:0]  wq[$], eq[$];
    logic [8:0]  rq[$];
    logic [2:0]  ops[4];
    logic [5:0]  seen;
    logic        acc, mt, spc, eor;
    int          bad_count, compares, ec, rc, n, k;

    ttfc_top #(.GAP_CLKS(8)) dut (.*);
    ttfc_xport xp (.clk(CLK), .write_data_ready_level(WRITE_DATA_READY_LEVEL),
        .fwd(TAPE_FORWARD), .rev(TAPE_REVERSE),
        .wind(TAPE_REWIND | TAPE_LOCAL), .sel(UNIT_SEL), .spc(spc),
        .eor(eor), .write_strobe_pulse(WRITE_STROBE_PULSE), .rec_end(TAPE_RECORD_END),
        .marker(TAPE_START_MARKER));

    initial begin
        CLK = 0;
        forever #4 CLK = ~CLK;
    end

    task check(input logic [17:0] got, input logic [17:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask

    task finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task idle;
        int t;
        t = 0;
        @(negedge CLK);
        while (CONTROLLER_READY_FLAG !== 1'b1) begin
            @(negedge CLK);
            t++;
            if (t > 3000) begin
                bad_count++;
                finish_test;
            end
        end
    endtask

    task go(input logic [2:0] f);
        @(negedge CLK);
        seen = 0;
        ec = 0;
        rc = 0;
        FUNC = f;
        GO = 1;
        @(negedge CLK);
        GO = 0;
        FUNC = ~f;
    endtask

    task load(input logic [15:0] cv, input logic [17:0] av);
        @(negedge CLK);
        {CNT_LOAD, ADDR_LOAD} = 2'h3;
        CNT_LOAD_VAL = cv;
        ADDR_LOAD_VAL = av;
        @(negedge CLK);
        {CNT_LOAD, ADDR_LOAD} = 2'h0;
    endtask

    // s picks data, CRC or LRC strobe
    task chr(input int s, input logic [8:0] ch);
        repeat (6) @(negedge CLK);
        TAPE_RD_CHAR = ch;
        {TAPE_LRC_STROBE, TAPE_CRC_STROBE, TAPE_RD_STROBE} = 3'h1 << s;
        @(negedge CLK);
        {TAPE_LRC_STROBE, TAPE_CRC_STROBE, TAPE_RD_STROBE} = 3'h0;
        TAPE_RD_CHAR = ~ch;
    endtask

    always @(posedge CLK) begin
        seen <= seen | {TAPE_LOCAL, TAPE_REWIND, TAPE_REVERSE,
                        TAPE_FORWARD, MEM_VALID, WRITE_DATA_READY_LEVEL};
        ec <= ec + TAPE_ERASE;
        rc <= rc + TAPE_RECORD_END;
        mt <= MEM_VALID && MEM_READY;
        if (mt)
            check({MEM_HIGH_BYTE, MEM_DATA}, rq.pop_front());
        if (WRITE_DATA_READY_LEVEL && WRITE_STROBE_PULSE) begin
            check(TAPE_WR_DATA, eq.pop_front());
            check(TAPE_WR_PARITY_ODD, !PARITY_EVEN);
        end
        if (WR_BYTE_VALID && WR_BYTE_READY)
            acc = 1;
    end

    // Byte feeder holds each offer until taken; random stalls
    always @(negedge CLK) begin
        if (acc)
            void'(wq.pop_front());
        if (acc || !WR_BYTE_VALID) begin
            WR_BYTE_VALID = wq.size() > 0 && $urandom_range(3) != 0;
            WR_BYTE = wq.size() > 0 ? wq[0] : ~WR_BYTE;
        end
        acc = 0;
        MEM_READY = $urandom_range(3) != 0;
    end

    initial begin
        {GO, UNIT_SEL, PARITY_EVEN, EXTENDED_GAP_WRITE, CNT_LOAD} = 0;
        {ADDR_LOAD, WR_BYTE_VALID, TAPE_RD_STROBE, TAPE_CRC_STROBE} = 0;
        {TAPE_LRC_STROBE, VPAR_ERR, LPAR_ERR, XFER_ERR, MEM_READY} = 0;
        {acc, mt, spc, eor, FUNC, WR_BYTE, TAPE_RD_CHAR} = 0;
        {CNT_LOAD_VAL, ADDR_LOAD_VAL, READ_CHECK_SELECT_REGISTER} = 0;
        {bad_count, compares, ec, rc, seen} = 0;
        UNIT_READY_IN = 2'h1;
        UNIT_REMOTE = 2'h3;
        ops = '{3'h7, 3'h4, 3'h5, 3'h0};
        RST_N = 0;
        void'($urandom(66));
        repeat (20) @(posedge CLK);
        @(negedge CLK);
        RST_N = 1;
        // Unit not ready: refused as illegal
        UNIT_SEL = 1;
        VPAR_ERR = 1;
        go(3'h2);
        idle;
        check(STATUS[14], 1);
        check(STATUS[13], 1);
        check(seen[0], 0);
        UNIT_SEL = 0;
        VPAR_ERR = 0;
        UNIT_READY_IN = 2'h3;
        for (k = 0; k < 4; k++) begin
            PARITY_EVEN = k[1];
            n = $urandom_range(6, 1);
            a = $urandom;
            for (int i = 0; i < n; i++) begin
                b = $urandom;
                wq.push_back(b);
                eq.push_back(b);
            end
            load(-n, a);
            go(k[0] ? 3'h6 : 3'h2);
            idle;
            check(ec, k[0] ? 8 : 0);
            check(RECORD_BYTE_COUNTER, 0);
            check(MEMORY_ADDRESS_POINTER, a + n);
            check(eq.size(), 0);
        end
        for (k = 0; k < 2; k++) begin
            EXTENDED_GAP_WRITE = k[0];
            eq.push_back(8'h13);
            go(3'h3);
            idle;
            check(ec, k[0] ? 0 : 8);
            check(eq.size(), 0);
        end
        EXTENDED_GAP_WRITE = 0;
        for (k = 0; k < 2; k++) begin
            READ_CHECK_SELECT_REGISTER = k[0] ? 16'h4000 : 16'h0;
            n = $urandom_range(7, 2);
            a = $urandom;
            c1 = $urandom;
            c2 = $urandom;
            load(-n, a);
            go(3'h1);
            for (int i = 0; i < n; i++) begin
                c = $urandom;
                rq.push_back({i[0], c[7:0]});
                chr(0, c);
            end
            chr(1, c1);
            chr(2, c2);
            eor = 1;
            repeat (2) @(negedge CLK);
            eor = 0;
            idle;
            check(DATA_BUFFER, k[0] ? c2[7:0] : c1[7:0]);
            check(RECORD_BYTE_COUNTER, 0);
            check(MEMORY_ADDRESS_POINTER, a + n);
            check(rq.size(), 0);
        end
        spc = 1;
        for (k = 0; k < 4; k++) begin
            load(-3, 0);
            go(ops[k]);
            idle;
            if (ops[k][2:1] == 2'h2) begin
                check(rc, 3);
                check(RECORD_BYTE_COUNTER, 0);
                check(seen, ops[k][0] ? 6'h08 : 6'h04);
            end else begin
                check(seen[1:0], 0);
                check(seen[5], ops[k] == 3'h0);
                check(seen[4] | seen[5], 1);
                check(STATUS[11], 1);
            end
        end
        finish_test;
    end
endmodule
`default_nettype wire
